//--- dv/acr_host.sv
/* host model: byte accesses on the register port of the config group.
   assumes the port takes its strobes on the rising edge of sys_clk. */
`timescale 1ns/1ns
module acr_host (
    input wire logic sys_clk,
    input wire logic [7:0] regRdData,
    output logic [8:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn
);
    // idle port until the first access
    initial {regAddr, regWrData, regWrEn, regRdEn} = '0;
    // one strobe edge; data turns over once released so stale bytes never match
    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d,
        output logic [7:0] rd);
        @(posedge sys_clk) #1;
        regAddr = a;
        regWrData = d;
        {regWrEn, regRdEn} = {w, !w};
        @(posedge sys_clk) #1;
        {regWrEn, regRdEn} = 2'h0;
        regWrData = ~d;
        rd = regRdData;
    endtask
endmodule // acr_host

//--- dv/application_config_registers_test.sv
/* self-checking bench for the application configuration register group.
   assumes the host model acr_host on the register port. */
`timescale 1ns/1ns
module application_config_registers_test;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrEn, regRdEn, regRdHit, dvcActiveA, dvcActiveB, ocHitA, ocHitB, ocEventA;
    logic ocEventB, generalPinZeroIn, generalPinZeroIsInput, nvmReloadReq, generalInputZero;
    logic generalInputOne, generalInputFour, bidirTwoIsOutput, bidirThreeIsOutput, powerGoodA;
    logic powerGoodB, readyA, readyB, generalOutputTwo, generalOutputThree, standAloneMode;
    logic generalOutputTwoRouted, generalOutputThreeRouted, nvmLoadDone, probeHit, probeRead;
    logic probeUpperPages;
    logic [8:0] regAddr;
    logic [7:0] regWrData, regRdData, probeAddr, activeBaseAddr, q;
    logic [4:0] pulldownEnable;
    logic [3:2] pullupEnable;
    logic [2:0] oscillatorTrim;
    logic [10:0] trimOffsetKhz;
    int num_errors = 0;
    int num_checks = 0;
    // distinct bases so fallback and primary can be told apart
    acr_config_regs #(.PRIMARY_BASE(8'h50), .HW_DEFAULT_BASE(8'h64)) dut (.*);
    acr_host host (.*);
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // all five registers plus one unmapped offset
    task automatic t_regs();
        logic [7:0] m [5] = '{acr_pkg::WMASK_OC_CONFIG, acr_pkg::WMASK_PIN_PULL,
            acr_pkg::WMASK_ROUTING, acr_pkg::WMASK_ROLE_TRIM, acr_pkg::WMASK_SECOND_ADDR};
        for (int i = 0; i < 6; i++) begin
            host.acc(1'b1, 9'h144 + 9'(i), 8'hFF, q);
            host.acc(1'b0, 9'h144 + 9'(i), 8'h00, q);
            chk(q === (i < 5 ? m[i] : 8'h00) && regRdHit === (i < 5), "readback");
        end
        $display("done regs");
    endtask
    // reserved code on a high source must drive nothing
    task automatic t_route();
        {powerGoodA, powerGoodB, readyA, readyB} = 4'hA;
        host.acc(1'b1, 9'h146, 8'h93, q);
        tk(2);
        chk({generalOutputTwo, generalOutputThree, generalOutputTwoRouted,
            generalOutputThreeRouted} === 4'hB, "power good route");
        host.acc(1'b1, 9'h146, 8'h06, q);
        tk(2);
        chk({generalOutputTwo, generalOutputThree, generalOutputTwoRouted,
            generalOutputThreeRouted} === 4'h7, "ready route");
        $display("done route");
    endtask
    // every trim code with stand-alone set, then companion role
    task automatic t_trim();
        for (int i = 0; i < 8; i++) begin
            host.acc(1'b1, 9'h147, 8'h80 | 8'(i), q);
            tk(2);
            chk(trimOffsetKhz === 11'(i) * 11'h0B4 && oscillatorTrim === 3'(i)
                && standAloneMode === 1'b1, "trim");
        end
        host.acc(1'b1, 9'h147, 8'h00, q);
        chk(standAloneMode === 1'b0, "role");
        $display("done trim");
    endtask
    // each pin selector, blank upper nibble, pin low, no selector
    task automatic t_addr();
        logic [7:0] r [5] = '{8'hA1, 8'h02, 8'hB3, 8'hB3, 8'hB0};
        logic [2:0] p [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        logic [7:0] e [5] = '{8'hA0, 8'h64, 8'h50, 8'hB0, 8'h50};
        for (int i = 0; i < 5; i++) begin
            {generalInputFour, generalInputOne, generalInputZero} = p[i];
            host.acc(1'b1, 9'h148, r[i], q);
            nvmLoadDone = 1'b1;
            tk(1);
            nvmLoadDone = 1'b0;
            tk(2);
            chk(activeBaseAddr === e[i], "base");
        end
        probeAddr = 8'h52;
        #1;
        chk({probeHit, probeRead, probeUpperPages} === 3'h5, "probe");
        probeAddr = 8'h53;
        #1;
        chk({probeHit, probeRead, probeUpperPages} === 3'h7, "probe");
        $display("done addr");
    endtask
    // pin rise reloads once only when enabled and an input
    task automatic t_reload();
        int n;
        for (int k = 0; k < 3; k++) begin
            host.acc(1'b1, 9'h144, 8'(k != 1), q);
            generalPinZeroIsInput = (k != 2);
            n = 0;
            generalPinZeroIn = 1'b1;
            repeat (3) begin
                tk(1);
                n += int'(nvmReloadReq === 1'b1);
            end
            generalPinZeroIn = 1'b0;
            chk(n == int'(k == 0), "reload");
        end
        $display("done reload");
    endtask
    // pulls follow pin direction on the two bidir pins
    task automatic t_pull();
        {bidirTwoIsOutput, bidirThreeIsOutput} = 2'h1;
        host.acc(1'b1, 9'h145, 8'h1F, q);
        tk(2);
        chk(pulldownEnable === 5'h17 && pullupEnable === 2'h2, "pulls");
        $display("done pull");
    endtask
    // A always reports, B masked through the transition plus its tail
    task automatic t_oc();
        host.acc(1'b1, 9'h144, 8'h08, q);
        {dvcActiveA, dvcActiveB, ocHitA, ocHitB} = 4'hF;
        tk(3);
        chk(ocEventA === 1'b1 && ocEventB === 1'b0, "transition mask");
        {dvcActiveA, dvcActiveB} = 2'h0;
        tk(150);
        chk(ocEventB === 1'b0, "tail mask");
        tk(200);
        chk(ocEventB === 1'b1, "tail end");
        $display("done oc");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the tests take about 470 cycles
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        {dvcActiveA, dvcActiveB, ocHitA, ocHitB, generalPinZeroIn, generalPinZeroIsInput,
            generalInputZero, generalInputOne, generalInputFour, bidirTwoIsOutput,
            bidirThreeIsOutput, powerGoodA, powerGoodB, readyA, readyB, nvmLoadDone,
            probeAddr} = '0;
        tk(5);
        rst_b = 1'b1;
        t_regs();
        t_route();
        t_trim();
        t_addr();
        t_reload();
        t_pull();
        t_oc();
        stop_test();
    end
endmodule // application_config_registers_test

//--- inc/acr_oc_if.sv
/*
 * signals between the register group and one over-current mask unit.
 * assumes one instance per converter, all on sys_clk.
 */
`timescale 1ns/1ns
interface acr_oc_if;
    logic [1:0] maskMode; // extra masking code
    logic dvcActive; // dynamic_voltage_transition in progress
    logic ocHit; // raw over-current hit
    logic usTick; // one-cycle pulse each microsecond
    logic ocEvent; // event passed on, registered
    logic masked; // mask window open
    modport ctrl (output maskMode, dvcActive, ocHit, usTick, input ocEvent, masked);
    modport mask (input maskMode, dvcActive, ocHit, usTick, output ocEvent, masked);
endinterface // acr_oc_if

//--- inc/acr_pkg.sv
/*
 * constants of the application configuration register group: offsets,
 * field positions, reset values, route codes and mask timing.
 * assumes a 100 MHz system clock and a byte-wide register port.
 */
// What this block does
// - mask codes suppress events during transition plus 2/10/50us
// - converter A mask bits 2:1, B 4:3
// - bit 0 enables pin-zero reload when input
// - bits 4,1,0 enable input pull-downs
// - bits 3,2 pull-down as input, pull-up output
// - converter B power-good route at bits 7:6
// - converter A power-good route at bits 5:4
// - converter B ready route at bits 3:2
// - converter A ready route at bits 1:0
// - role bit: clear companion, set stand-alone
// - trim bits 2:0 add 180 kHz steps
// - bits 7:4 give upper second base nibble
// - second base only with a pin selected
// - base+0/+1 pages 0-1, +2/+3 pages 2-3
// - upper nibble 0000 falls back to default
// - pin select: none, input 0, 1, 4
package acr_pkg;
    // register offsets, 9-bit register space
    localparam logic [8:0] OFS_OC_CONFIG = 9'h144;
    localparam logic [8:0] OFS_PIN_PULL = 9'h145;
    localparam logic [8:0] OFS_ROUTING = 9'h146;
    localparam logic [8:0] OFS_ROLE_TRIM = 9'h147;
    localparam logic [8:0] OFS_SECOND_ADDR = 9'h148;
    // reset values, none documented so all clear
    localparam logic [7:0] RST_OC_CONFIG = 8'h00;
    localparam logic [7:0] RST_PIN_PULL = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    localparam logic [7:0] RST_ROLE_TRIM = 8'h00;
    localparam logic [7:0] RST_SECOND_ADDR = 8'h00;
    // over-current configuration fields
    localparam int BIT_RELOAD_EN = 0;
    localparam int POS_MASK_A = 1;
    localparam int POS_MASK_B = 3;
    // pull fields
    localparam int BIT_PULL_IN0 = 0;
    localparam int BIT_PULL_IN1 = 1;
    localparam int BIT_PULL_BIDIR2 = 2;
    localparam int BIT_PULL_BIDIR3 = 3;
    localparam int BIT_PULL_IN4 = 4;
    // routing fields
    localparam int POS_READY_A = 0;
    localparam int POS_READY_B = 2;
    localparam int POS_PG_A = 4;
    localparam int POS_PG_B = 6;
    // role and trim fields
    localparam int POS_TRIM = 0;
    localparam int BIT_STAND_ALONE = 7;
    localparam logic [10:0] TRIM_STEP_KHZ = 11'h0B4;
    // second address fields
    localparam int POS_ALT_SEL = 0;
    localparam int POS_BASE_UPPER = 4;
    // writable bits per register, the rest read zero
    localparam logic [7:0] WMASK_OC_CONFIG = 8'h1F;
    localparam logic [7:0] WMASK_PIN_PULL = 8'h1F;
    localparam logic [7:0] WMASK_ROUTING = 8'hFF;
    localparam logic [7:0] WMASK_ROLE_TRIM = 8'h87;
    localparam logic [7:0] WMASK_SECOND_ADDR = 8'hF3;
    // route codes, 11 reserved and drives nothing
    localparam logic [1:0] ROUTE_NONE = 2'h0;
    localparam logic [1:0] ROUTE_OUT_TWO = 2'h1;
    localparam logic [1:0] ROUTE_OUT_THREE = 2'h2;
    // alternative address pin codes
    localparam logic [1:0] ALT_PIN_NONE = 2'h0;
    localparam logic [1:0] ALT_PIN_IN0 = 2'h1;
    localparam logic [1:0] ALT_PIN_IN1 = 2'h2;
    localparam logic [1:0] ALT_PIN_IN4 = 2'h3;
    // mask codes
    localparam logic [1:0] MASK_OFF = 2'h0;
    localparam logic [1:0] MASK_EXTRA_2 = 2'h1;
    localparam logic [1:0] MASK_EXTRA_10 = 2'h2;
    localparam logic [1:0] MASK_EXTRA_50 = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] EXTRA_US_2 = 6'h02;
    localparam logic [5:0] EXTRA_US_10 = 6'h0A;
    localparam logic [5:0] EXTRA_US_50 = 6'h32;
endpackage

//--- src/acr_config_regs.sv
/*
 * application configuration register group: over-current masking,
 * reload pin, pin pulls, indicator routing, role, oscillator trim and
 * second two-wire base address.
 * assumes the interface logic delivers decoded byte accesses on the
 * register port and that all pin inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ns
module acr_config_regs #(
    parameter logic [7:0] PRIMARY_BASE = 8'hD0, // primary base, plain default
    parameter logic [7:0] HW_DEFAULT_BASE = 8'hD0 // fallback base, plain default
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [8:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdHit,
    // converter events
    input wire logic dvcActiveA,
    input wire logic dvcActiveB,
    input wire logic ocHitA,
    input wire logic ocHitB,
    output logic ocEventA,
    output logic ocEventB,
    // reload
    input wire logic generalPinZeroIn,
    input wire logic generalPinZeroIsInput,
    output logic nvmReloadReq,
    // general inputs
    input wire logic generalInputZero,
    input wire logic generalInputOne,
    input wire logic generalInputFour,
    input wire logic bidirTwoIsOutput,
    input wire logic bidirThreeIsOutput,
    output logic [4:0] pulldownEnable,
    output logic [3:2] pullupEnable,
    // indicator routing
    input wire logic powerGoodA,
    input wire logic powerGoodB,
    input wire logic readyA,
    input wire logic readyB,
    output logic generalOutputTwo,
    output logic generalOutputThree,
    output logic generalOutputTwoRouted,
    output logic generalOutputThreeRouted,
    // role and trim
    output logic standAloneMode,
    output logic [2:0] oscillatorTrim,
    output logic [10:0] trimOffsetKhz,
    // address
    input wire logic nvmLoadDone,
    input wire logic [7:0] probeAddr,
    output logic [7:0] activeBaseAddr,
    output logic probeHit,
    output logic probeRead,
    output logic probeUpperPages
);
    ////////////////////////////////////////////////////////////////////
    // register storage and write decode
    logic [7:0] ocConfig_q; // over-current config
    logic [7:0] pinPullConfig_q; // pin_pull_config
    logic [7:0] indicatorRoutingConfig_q; // indicator_routing_config
    logic [7:0] roleAndOscillatorTrim_q; // role_and_oscillator_trim
    logic [7:0] secondAddressConfig_q; // second_address_config
    logic selOc, selPull, selRoute, selRole, selAddr, selAny;
    logic [7:0] rdMux; // read selection

    assign selOc = regAddr == acr_pkg::OFS_OC_CONFIG;
    assign selPull = regAddr == acr_pkg::OFS_PIN_PULL;
    assign selRoute = regAddr == acr_pkg::OFS_ROUTING;
    assign selRole = regAddr == acr_pkg::OFS_ROLE_TRIM;
    assign selAddr = regAddr == acr_pkg::OFS_SECOND_ADDR;
    assign selAny = selOc || selPull || selRoute || selRole || selAddr;

    // byte writes, bits outside the write mask stay zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ocConfig_q <= acr_pkg::RST_OC_CONFIG;
            pinPullConfig_q <= acr_pkg::RST_PIN_PULL;
            indicatorRoutingConfig_q <= acr_pkg::RST_ROUTING;
            roleAndOscillatorTrim_q <= acr_pkg::RST_ROLE_TRIM;
            secondAddressConfig_q <= acr_pkg::RST_SECOND_ADDR;
        end else if (regWrEn) begin
            if (selOc) ocConfig_q <= regWrData & acr_pkg::WMASK_OC_CONFIG;
            if (selPull) pinPullConfig_q <= regWrData & acr_pkg::WMASK_PIN_PULL;
            if (selRoute) indicatorRoutingConfig_q <= regWrData & acr_pkg::WMASK_ROUTING;
            if (selRole) roleAndOscillatorTrim_q <= regWrData & acr_pkg::WMASK_ROLE_TRIM;
            if (selAddr) secondAddressConfig_q <= regWrData & acr_pkg::WMASK_SECOND_ADDR;
        end
    end

    // read data one cycle after the strobe, unmapped reads give zero
    assign rdMux = selOc ? ocConfig_q :
                   selPull ? pinPullConfig_q :
                   selRoute ? indicatorRoutingConfig_q :
                   selRole ? roleAndOscillatorTrim_q :
                   selAddr ? secondAddressConfig_q : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
            regRdHit <= 1'b0;
        end else if (regRdEn) begin
            regRdData <= rdMux;
            regRdHit <= selAny;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // over-current masking, one unit per converter
    logic [1:0] maskCode [2]; // per-converter mask code
    logic dvcIn [2];
    logic hitIn [2];
    logic evOut [2];
    logic [6:0] tickCnt_q; // microsecond divider
    logic usTick;

    assign maskCode[0] = ocConfig_q[acr_pkg::POS_MASK_A +: 2];
    assign maskCode[1] = ocConfig_q[acr_pkg::POS_MASK_B +: 2];
    assign dvcIn[0] = dvcActiveA;
    assign dvcIn[1] = dvcActiveB;
    assign hitIn[0] = ocHitA;
    assign hitIn[1] = ocHitB;
    assign usTick = tickCnt_q == 7'(acr_pkg::TICK_CYCLES - 1);
    assign ocEventA = evOut[0];
    assign ocEventB = evOut[1];

    // free-running divider, tick once per microsecond
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tickCnt_q <= 7'h00;
        end else begin
            tickCnt_q <= usTick ? 7'h00 : tickCnt_q + 7'h01;
        end
    end

    acr_oc_if ocLink [2] ();
    for (genvar c = 0; c < 2; c++) begin : g_conv
        assign ocLink[c].maskMode = maskCode[c];
        assign ocLink[c].dvcActive = dvcIn[c];
        assign ocLink[c].ocHit = hitIn[c];
        assign ocLink[c].usTick = usTick;
        assign evOut[c] = ocLink[c].ocEvent;
        acr_oc_mask u_mask (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .oc(ocLink[c])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // reload from non-volatile memory on a rising edge of pin zero
    logic pinZero_q; // previous pin level
    logic reloadEn;
    assign reloadEn = ocConfig_q[acr_pkg::BIT_RELOAD_EN];

    // edge detect keeps a held-high pin from reloading over and over
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pinZero_q <= 1'b0;
            nvmReloadReq <= 1'b0;
        end else begin
            pinZero_q <= generalPinZeroIn;
            nvmReloadReq <= reloadEn && generalPinZeroIsInput &&
                            generalPinZeroIn && !pinZero_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pulls: bidirectional pins pull down as inputs, pull up as outputs
    logic [4:0] pullBits;
    assign pullBits = pinPullConfig_q[4:0];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pulldownEnable <= 5'h00;
            pullupEnable <= 2'h0;
        end else begin
            pulldownEnable[acr_pkg::BIT_PULL_IN0] <= pullBits[acr_pkg::BIT_PULL_IN0];
            pulldownEnable[acr_pkg::BIT_PULL_IN1] <= pullBits[acr_pkg::BIT_PULL_IN1];
            pulldownEnable[acr_pkg::BIT_PULL_IN4] <= pullBits[acr_pkg::BIT_PULL_IN4];
            pulldownEnable[acr_pkg::BIT_PULL_BIDIR2] <=
                pullBits[acr_pkg::BIT_PULL_BIDIR2] && !bidirTwoIsOutput;
            pulldownEnable[acr_pkg::BIT_PULL_BIDIR3] <=
                pullBits[acr_pkg::BIT_PULL_BIDIR3] && !bidirThreeIsOutput;
            pullupEnable[2] <= pullBits[acr_pkg::BIT_PULL_BIDIR2] && bidirTwoIsOutput;
            pullupEnable[3] <= pullBits[acr_pkg::BIT_PULL_BIDIR3] && bidirThreeIsOutput;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // indicator routing, several sources on one output are or-ed
    logic [1:0] pgRouteB, pgRouteA, rdyRouteB, rdyRouteA;
    logic twoSrc, threeSrc, twoUsed, threeUsed;

    assign pgRouteB = indicatorRoutingConfig_q[acr_pkg::POS_PG_B +: 2];
    assign pgRouteA = indicatorRoutingConfig_q[acr_pkg::POS_PG_A +: 2];
    assign rdyRouteB = indicatorRoutingConfig_q[acr_pkg::POS_READY_B +: 2];
    assign rdyRouteA = indicatorRoutingConfig_q[acr_pkg::POS_READY_A +: 2];
    assign twoSrc = (pgRouteB == acr_pkg::ROUTE_OUT_TWO && powerGoodB) ||
                    (pgRouteA == acr_pkg::ROUTE_OUT_TWO && powerGoodA) ||
                    (rdyRouteB == acr_pkg::ROUTE_OUT_TWO && readyB) ||
                    (rdyRouteA == acr_pkg::ROUTE_OUT_TWO && readyA);
    assign threeSrc = (pgRouteB == acr_pkg::ROUTE_OUT_THREE && powerGoodB) ||
                      (pgRouteA == acr_pkg::ROUTE_OUT_THREE && powerGoodA) ||
                      (rdyRouteB == acr_pkg::ROUTE_OUT_THREE && readyB) ||
                      (rdyRouteA == acr_pkg::ROUTE_OUT_THREE && readyA);
    assign twoUsed = pgRouteB == acr_pkg::ROUTE_OUT_TWO || pgRouteA == acr_pkg::ROUTE_OUT_TWO ||
                     rdyRouteB == acr_pkg::ROUTE_OUT_TWO || rdyRouteA == acr_pkg::ROUTE_OUT_TWO;
    assign threeUsed = pgRouteB == acr_pkg::ROUTE_OUT_THREE ||
                       pgRouteA == acr_pkg::ROUTE_OUT_THREE ||
                       rdyRouteB == acr_pkg::ROUTE_OUT_THREE ||
                       rdyRouteA == acr_pkg::ROUTE_OUT_THREE;

    // registered so the pins never glitch while a route is rewritten
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            generalOutputTwo <= 1'b0;
            generalOutputThree <= 1'b0;
            generalOutputTwoRouted <= 1'b0;
            generalOutputThreeRouted <= 1'b0;
        end else begin
            generalOutputTwo <= twoSrc;
            generalOutputThree <= threeSrc;
            generalOutputTwoRouted <= twoUsed;
            generalOutputThreeRouted <= threeUsed;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // role and oscillator trim straight from the register
    assign standAloneMode = roleAndOscillatorTrim_q[acr_pkg::BIT_STAND_ALONE];
    assign oscillatorTrim = roleAndOscillatorTrim_q[acr_pkg::POS_TRIM +: 3];

    // offset in kHz for whoever programs the analog trim
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            trimOffsetKhz <= 11'h000;
        end else begin
            trimOffsetKhz <= 11'({8'h00, oscillatorTrim} * acr_pkg::TRIM_STEP_KHZ);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // base address selection
    logic [1:0] altSel;
    logic [3:0] baseUpper;
    logic selPinLevel;
    logic started_q; // first cycle after reset done
    logic altPin_q; // pin level caught at start-up
    logic [7:0] secondBase;
    logic [7:0] baseNext;

    assign altSel = secondAddressConfig_q[acr_pkg::POS_ALT_SEL +: 2];
    assign baseUpper = secondAddressConfig_q[acr_pkg::POS_BASE_UPPER +: 4];
    assign selPinLevel = (altSel == acr_pkg::ALT_PIN_IN0) ? generalInputZero :
                         (altSel == acr_pkg::ALT_PIN_IN1) ? generalInputOne :
                         (altSel == acr_pkg::ALT_PIN_IN4) ? generalInputFour :
                         1'b0;
    assign secondBase = (baseUpper == 4'h0) ? HW_DEFAULT_BASE : {baseUpper, 4'h0};
    assign baseNext = (altSel != acr_pkg::ALT_PIN_NONE && altPin_q) ?
                      secondBase : PRIMARY_BASE;

    // pin is caught once after reset and again after each settings load,
    // so a live toggle on the pin cannot move the address mid-transfer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            started_q <= 1'b0;
            altPin_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
            if (!started_q || nvmLoadDone) altPin_q <= selPinLevel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            activeBaseAddr <= PRIMARY_BASE;
        end else begin
            activeBaseAddr <= baseNext;
        end
    end

    // four consecutive bus addresses: write/read, low pages then high
    assign probeHit = probeAddr[7:2] == activeBaseAddr[7:2];
    assign probeRead = probeHit && probeAddr[0];
    assign probeUpperPages = probeHit && probeAddr[1];

    ////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    reload_pulse_a: assert property (nvmReloadReq |->
        $past(reloadEn) && $past(generalPinZeroIsInput) && $past(generalPinZeroIn) ##1 !nvmReloadReq)
        else $error("reload without cause");
    pull_input_a: assert property (1'b1 |=>
        pulldownEnable[acr_pkg::BIT_PULL_IN4] == $past(pinPullConfig_q[acr_pkg::BIT_PULL_IN4]))
        else $error("input four pull wrong");
    bidir_pull_a: assert property (1'b1 |=> !(pulldownEnable[2] && pullupEnable[2]))
        else $error("both pulls on bidir two");
    pg_route_a: assert property (pgRouteB == acr_pkg::ROUTE_OUT_THREE && powerGoodB
        |=> generalOutputThree && generalOutputThreeRouted)
        else $error("power-good B not routed");
    ready_route_a: assert property (rdyRouteA == acr_pkg::ROUTE_OUT_TWO && readyA
        |=> generalOutputTwo)
        else $error("ready A not routed");
    trim_value_a: assert property ($stable(oscillatorTrim) [*2] |->
        trimOffsetKhz == 11'(oscillatorTrim) * acr_pkg::TRIM_STEP_KHZ)
        else $error("trim offset wrong");
    primary_base_a: assert property ($past(altSel) == acr_pkg::ALT_PIN_NONE && started_q
        |-> activeBaseAddr == PRIMARY_BASE)
        else $error("second base without pin");
    fallback_base_a: assert property (altPin_q && altSel != acr_pkg::ALT_PIN_NONE &&
        baseUpper == 4'h0 |=> activeBaseAddr == HW_DEFAULT_BASE || $changed(secondAddressConfig_q))
        else $error("unprogrammed base used");
    reserved_read_a: assert property (regRdEn && selAddr |=> regRdData[3:2] == 2'h0)
        else $error("reserved bits read set");
    probe_page_a: assert property (probeAddr == activeBaseAddr + 8'h03
        |-> probeHit && probeRead && probeUpperPages)
        else $error("page two-three read missed");
    role_bit_a: assert property (regWrEn && selRole |=>
        standAloneMode == $past(regWrData[acr_pkg::BIT_STAND_ALONE]))
        else $error("role bit not taken");
    second_base_c: cover property (altPin_q && baseUpper != 4'h0 && altSel != 2'h0);
    reload_c: cover property (nvmReloadReq);
    route_both_c: cover property (generalOutputTwo && generalOutputThree);
endmodule // acr_config_regs

//--- src/acr_oc_mask.sv
/*
 * over-current event mask for one converter: suppresses hits during a
 * voltage transition and for a coded extra time afterwards.
 * assumes a microsecond tick pulse and synchronous inputs.
 */
`timescale 1ns/1ns
module acr_oc_mask (
    input wire logic sys_clk,
    input wire logic rst_b,
    acr_oc_if.mask oc
);
    logic [5:0] extraUs; // extra window for the current code
    logic [5:0] holdCnt_q; // ticks left after transition end
    logic [5:0] holdCnt_d;
    logic maskOn; // window open
    logic ocEvent_q;
    ////////////////////////////////////////////////////////////////////
    // one tick extra, since tick phase is unknown the window is never short
    assign extraUs = (oc.maskMode == acr_pkg::MASK_EXTRA_2) ? acr_pkg::EXTRA_US_2 + 6'h01 :
                     (oc.maskMode == acr_pkg::MASK_EXTRA_10) ? acr_pkg::EXTRA_US_10 + 6'h01 :
                     acr_pkg::EXTRA_US_50 + 6'h01;
    assign holdCnt_d = oc.dvcActive ? extraUs :
                       (oc.usTick && holdCnt_q != 6'h00) ? holdCnt_q - 6'h01 : holdCnt_q;
    assign maskOn = (oc.maskMode != acr_pkg::MASK_OFF) &&
                    (oc.dvcActive || holdCnt_q != 6'h00);
    assign oc.masked = maskOn;
    assign oc.ocEvent = ocEvent_q;

    // hold counter reloads all through the transition
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            holdCnt_q <= 6'h00;
        end else begin
            holdCnt_q <= holdCnt_d;
        end
    end

    // events pass one cycle later unless masked
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ocEvent_q <= 1'b0;
        end else begin
            ocEvent_q <= oc.ocHit && !maskOn;
        end
    end

    ////////////////////////////////////////////////////////////////////
    localparam int WAIT_LO = 1;
    localparam int WAIT_HI = 1000;
    mask_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        oc.maskMode == acr_pkg::MASK_OFF |=> ocEvent_q == $past(oc.ocHit))
        else $error("hit lost with masking off");
    mask_dvc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        oc.dvcActive && oc.maskMode != acr_pkg::MASK_OFF && oc.ocHit |=> !ocEvent_q)
        else $error("hit passed during transition");
    mask_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(oc.dvcActive) && oc.maskMode == acr_pkg::MASK_EXTRA_2 |->
        maskOn ##[WAIT_LO:WAIT_HI] !maskOn)
        else $error("short window wrong length");
    mask_window_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(oc.dvcActive) && oc.maskMode == acr_pkg::MASK_EXTRA_50 ##[1:10] oc.ocHit);
endmodule // acr_oc_mask
